// ===== utc_pkg.sv
// constants, types and helpers for the uart driven ddr throughput test
package utc_pkg;
   localparam logic [7:0]  HS_BYTE     = 8'h63;
   localparam logic [7:0]  ACK_BYTE    = 8'h61;
   localparam logic [7:0]  CMD_WR_BYTE = 8'h25;
   localparam logic [7:0]  CMD_RD_BYTE = 8'h26;
   localparam int          BLOCK_BYTES = 2048;
   localparam int          BEAT_BYTES  = 8;
   localparam int          BEATS       = BLOCK_BYTES / BEAT_BYTES;
   localparam logic [7:0]  LAST_BEAT   = 8'hFF;
   localparam logic [3:0]  BURST_LEN   = 4'hF;
   localparam logic [2:0]  LAST_REP    = 3'h7;
   localparam int          REPS        = 8;
   localparam logic [3:0]  LAST_CBYTE  = 4'hF;
   localparam logic [15:0] CNT_MAX     = 16'hFFFF;
   localparam logic [15:0] CNT_RST     = 16'h0000;
   localparam logic [7:0]  BYTE_RST    = 8'h00;

   typedef enum logic {UTC_DIR_WRITE, UTC_DIR_READ} utc_dir_t;

   typedef enum logic [2:0] {
      T_WAIT_HS, T_ACK, T_WAIT_CMD, T_RUN, T_SEND
   } utc_ctl_state_t;

   typedef enum logic [2:0] {
      M_IDLE, M_AW, M_WF, M_WD, M_WH, M_B, M_AR, M_R
   } utc_mst_state_t;

   typedef struct packed {
      logic [2:0]  addr;
      logic [15:0] value;
   } utc_cnt_t;

   // row-bank-column map: column in [10:0], bank [12:11], row [13]
   function automatic logic [31:0] utc_burst_addr(input logic [2:0] rep,
                                                  input logic [7:0] beat);
      utc_burst_addr = {18'h00000, rep, beat, 3'h0};
   endfunction : utc_burst_addr

   // {valid, is_read}
   function automatic logic [1:0] utc_decode(input logic [7:0] b);
      if (b == CMD_WR_BYTE) begin
         utc_decode = 2'h2;
      end else if (b == CMD_RD_BYTE) begin
         utc_decode = 2'h3;
      end else begin
         utc_decode = 2'h0;
      end
   endfunction : utc_decode
endpackage : utc_pkg

// ===== utc_axi_master.sv
// axi master moving eight 2 KB blocks and timing each one
`timescale 1ns/1ps
module utc_axi_master (
   input  wire logic              clk_in,
   input  wire logic              rst_b_in,
   input  wire logic              start_in,
   input  wire utc_pkg::utc_dir_t dir_in,
   output logic                   done_out,
   output logic                   cnt_valid_out,
   output utc_pkg::utc_cnt_t      cnt_out,
   output logic [7:0]             ram_addr_out,
   input  wire logic [63:0]       ram_rd_data_in,
   output logic                   ram_we_out,
   output logic [63:0]            ram_wdata_out,
   output logic [31:0]            awaddr_out,
   output logic [3:0]             awlen_out,
   output logic                   awvalid_out,
   input  wire logic              awready_in,
   output logic [63:0]            wdata_out,
   output logic                   wlast_out,
   output logic                   wvalid_out,
   input  wire logic              wready_in,
   input  wire logic              bvalid_in,
   output logic                   bready_out,
   output logic [31:0]            araddr_out,
   output logic                   arvalid_out,
   input  wire logic              arready_in,
   input  wire logic [63:0]       rdata_in,
   input  wire logic              rvalid_in,
   output logic                   rready_out
);
   utc_pkg::utc_mst_state_t state, next_state;
   utc_pkg::utc_dir_t       dir, next_dir;
   logic [2:0]  rep, next_rep;
   logic [7:0]  beat, next_beat;
   logic [15:0] cycles, next_cycles;
   logic [63:0] data, next_data;
   logic [31:0] addr, next_addr;
   logic awv, next_awv, arv, next_arv, wv, next_wv, wl, next_wl;
   logic bry, next_bry, rry, next_rry, we, next_we, dn, next_dn;
   logic cv, next_cv;
   utc_pkg::utc_cnt_t cnt, next_cnt;
   logic [7:0] raddr, next_raddr;

   always_comb begin
      next_state = state;  next_dir = dir;  next_rep = rep;
      next_beat = beat;  next_data = data;  next_addr = addr;
      next_awv = awv;  next_arv = arv;  next_wv = wv;  next_wl = wl;
      next_bry = bry;  next_rry = rry;  next_raddr = raddr;
      next_cnt = cnt;  next_we = 1'b0;  next_dn = 1'b0;  next_cv = 1'b0;
      next_cycles = cycles;
      // saturate rather than wrap so a stalled slave reads as slowest
      if (state != utc_pkg::M_IDLE && cycles != utc_pkg::CNT_MAX) begin
         next_cycles = cycles + 16'h0001;
      end
      case (state)
         utc_pkg::M_IDLE: begin
            if (start_in) begin
               next_dir = dir_in;
               next_rep = 3'h0;
               next_beat = 8'h00;
               next_cycles = utc_pkg::CNT_RST;
               next_addr = utc_pkg::utc_burst_addr(3'h0, 8'h00);
               if (dir_in == utc_pkg::UTC_DIR_WRITE) begin
                  next_awv = 1'b1;
                  next_state = utc_pkg::M_AW;
               end else begin
                  next_arv = 1'b1;
                  next_state = utc_pkg::M_AR;
               end
            end
         end
         utc_pkg::M_AW: begin
            if (awready_in) begin
               next_awv = 1'b0;
               next_raddr = beat;
               next_state = utc_pkg::M_WF;
            end
         end
         utc_pkg::M_WF: next_state = utc_pkg::M_WD;
         utc_pkg::M_WD: begin
            next_data = ram_rd_data_in;
            next_wv = 1'b1;
            next_wl = (beat[3:0] == utc_pkg::BURST_LEN);
            next_state = utc_pkg::M_WH;
         end
         utc_pkg::M_WH: begin
            if (wready_in) begin
               next_wv = 1'b0;
               next_wl = 1'b0;
               next_beat = beat + 8'h01;
               next_raddr = beat + 8'h01;
               if (wl) begin
                  next_bry = 1'b1;
                  next_state = utc_pkg::M_B;
               end else begin
                  next_state = utc_pkg::M_WF;
               end
            end
         end
         utc_pkg::M_B: begin
            if (bvalid_in) begin
               next_bry = 1'b0;
               if (beat == 8'h00) begin
                  next_state = utc_pkg::M_IDLE;
                  next_cv = 1'b1;
               end else begin
                  next_addr = utc_pkg::utc_burst_addr(rep, beat);
                  next_awv = 1'b1;
                  next_state = utc_pkg::M_AW;
               end
            end
         end
         utc_pkg::M_AR: begin
            if (arready_in) begin
               next_arv = 1'b0;
               next_rry = 1'b1;
               next_state = utc_pkg::M_R;
            end
         end
         default: begin
            if (rvalid_in) begin
               next_we = 1'b1;
               next_raddr = beat;
               next_data = rdata_in;
               next_beat = beat + 8'h01;
               if (beat[3:0] == utc_pkg::BURST_LEN) begin
                  next_rry = 1'b0;
                  if (beat == utc_pkg::LAST_BEAT) begin
                     next_state = utc_pkg::M_IDLE;
                     next_cv = 1'b1;
                  end else begin
                     next_addr = utc_pkg::utc_burst_addr(rep, beat + 8'h01);
                     next_arv = 1'b1;
                     next_state = utc_pkg::M_AR;
                  end
               end
            end
         end
      endcase
      // end of one block: report its count and chain the next repetition, or raise done after the eighth
      if (next_cv) begin
         next_cnt = '{addr: rep, value: cycles};
         next_cycles = utc_pkg::CNT_RST;
         if (rep == utc_pkg::LAST_REP) begin
            next_dn = 1'b1;
         end else begin
            next_rep = rep + 3'h1;
            next_beat = 8'h00;
            next_addr = utc_pkg::utc_burst_addr(rep + 3'h1, 8'h00);
            next_awv = (dir == utc_pkg::UTC_DIR_WRITE);
            next_arv = (dir == utc_pkg::UTC_DIR_READ);
            next_state = (dir == utc_pkg::UTC_DIR_WRITE) ?
                         utc_pkg::M_AW : utc_pkg::M_AR;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state <= utc_pkg::M_IDLE;  dir <= utc_pkg::UTC_DIR_WRITE;
         rep <= 3'h0;  beat <= 8'h00;  cycles <= utc_pkg::CNT_RST;
         data <= 64'h0;  addr <= 32'h0;  awv <= 1'b0;  arv <= 1'b0;
         wv <= 1'b0;  wl <= 1'b0;  bry <= 1'b0;  rry <= 1'b0;
         we <= 1'b0;  dn <= 1'b0;  cv <= 1'b0;  raddr <= 8'h00;
         cnt <= '0;
      end else begin
         state <= next_state;  dir <= next_dir;  rep <= next_rep;
         beat <= next_beat;  cycles <= next_cycles;  data <= next_data;
         addr <= next_addr;  awv <= next_awv;  arv <= next_arv;
         wv <= next_wv;  wl <= next_wl;  bry <= next_bry;  rry <= next_rry;
         we <= next_we;  dn <= next_dn;  cv <= next_cv;  raddr <= next_raddr;
         cnt <= next_cnt;
      end
   end

   assign done_out = dn;       assign cnt_valid_out = cv;
   assign cnt_out = cnt;       assign ram_addr_out = raddr;
   assign ram_we_out = we;     assign ram_wdata_out = data;
   assign awaddr_out = addr;   assign awlen_out = utc_pkg::BURST_LEN;
   assign awvalid_out = awv;   assign wdata_out = data;
   assign wlast_out = wl;      assign wvalid_out = wv;
   assign bready_out = bry;    assign araddr_out = addr;
   assign arvalid_out = arv;   assign rready_out = rry;

   // helper counters watched only by the checks below
   logic [8:0] chk_beats;
   logic [3:0] chk_reps;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         chk_beats <= 9'h000;
         chk_reps  <= 4'h0;
      end else begin
         if (cv) begin
            chk_beats <= 9'h000;
         end else if ((wv && wready_in) || (rry && rvalid_in)) begin
            chk_beats <= chk_beats + 9'h001;
         end
         if (start_in && state == utc_pkg::M_IDLE) begin
            chk_reps <= 4'h0;
         end else if (cv) begin
            chk_reps <= chk_reps + 4'h1;
         end
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);

   AST_ROWBANK_WR: assert property (awv |-> addr[31:14] == 18'h0)
      else $error("write outside rows 0-1 of banks 0-3");
   AST_ROWBANK_RD: assert property (arv |-> addr[31:14] == 18'h0)
      else $error("read outside rows 0-1 of banks 0-3");
   AST_BLOCK_WR: assert property (
      cv && dir == utc_pkg::UTC_DIR_WRITE |-> chk_beats == 9'h100)
      else $error("write block not 2 KB");
   AST_BLOCK_RD: assert property (
      cv && dir == utc_pkg::UTC_DIR_READ |-> chk_beats == 9'h100)
      else $error("read block not 2 KB");
   // done coincides with the eighth report, before the helper counts it
   AST_EIGHT_WR: assert property (
      dn && dir == utc_pkg::UTC_DIR_WRITE |-> cv && chk_reps == 4'h7)
      else $error("write not repeated eight times");
   AST_EIGHT_RD: assert property (
      dn && dir == utc_pkg::UTC_DIR_READ |-> cv && chk_reps == 4'h7)
      else $error("read not repeated eight times");
   AST_CNT_ADDR: assert property (cv |-> cnt.addr == chk_reps[2:0])
      else $error("count address out of sequence");
   AST_CNT_VALUE: assert property (
      cv |-> cnt.value > 16'(utc_pkg::BEATS) ##1 !cv)
      else $error("throughput count too small");
endmodule : utc_axi_master

// ===== utc_top.sv
// uart command control, count ram and axi master of the throughput test
`timescale 1ns/1ps
module utc_top (
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   input  wire logic        rx_valid_in,
   input  wire logic [7:0]  rx_data_in,
   input  wire logic        tx_ready_in,
   output logic             tx_valid_out,
   output logic [7:0]       tx_data_out,
   output logic             busy_out,
   output logic [7:0]       ram_addr_out,
   input  wire logic [63:0] ram_rd_data_in,
   output logic             ram_we_out,
   output logic [63:0]      ram_wdata_out,
   output logic [31:0]      awaddr_out,
   output logic [3:0]       awlen_out,
   output logic             awvalid_out,
   input  wire logic        awready_in,
   output logic [63:0]      wdata_out,
   output logic             wlast_out,
   output logic             wvalid_out,
   input  wire logic        wready_in,
   input  wire logic        bvalid_in,
   output logic             bready_out,
   output logic [31:0]      araddr_out,
   output logic             arvalid_out,
   input  wire logic        arready_in,
   input  wire logic [63:0] rdata_in,
   input  wire logic        rvalid_in,
   output logic             rready_out
);
   utc_pkg::utc_ctl_state_t state, next_state;
   utc_pkg::utc_dir_t       dir, next_dir;
   logic       expect_read, next_expect_read;
   logic       tx_valid, next_tx_valid;
   logic [7:0] tx_data, next_tx_data;
   logic       start, next_start;
   logic [3:0] byte_idx, next_byte_idx;
   logic [1:0] decoded;
   logic       mst_done;
   logic       cnt_valid;
   utc_pkg::utc_cnt_t cnt;

   // throughput_count_ram: eight 16-bit words in, sixteen bytes out
   logic [15:0] count_mem [utc_pkg::REPS];
   logic [15:0] next_count_mem [utc_pkg::REPS];

   function automatic logic [7:0] cnt_byte(input logic [15:0] w,
                                           input logic        hi);
      cnt_byte = hi ? w[15:8] : w[7:0];
   endfunction : cnt_byte

   assign decoded = utc_pkg::utc_decode(rx_data_in);

   always_comb begin
      for (int i = 0; i < utc_pkg::REPS; i++) begin
         next_count_mem[i] = count_mem[i];
      end
      if (cnt_valid) begin
         next_count_mem[cnt.addr] = cnt.value;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int i = 0; i < utc_pkg::REPS; i++) begin
            count_mem[i] <= utc_pkg::CNT_RST;
         end
      end else begin
         for (int i = 0; i < utc_pkg::REPS; i++) begin
            count_mem[i] <= next_count_mem[i];
         end
      end
   end

   always_comb begin
      next_state = state;
      next_dir = dir;
      next_expect_read = expect_read;
      next_tx_valid = tx_valid;
      next_tx_data = tx_data;
      next_start = 1'b0;
      next_byte_idx = byte_idx;
      case (state)
         utc_pkg::T_WAIT_HS: begin
            // every byte but the handshake is dropped here
            if (rx_valid_in && rx_data_in == utc_pkg::HS_BYTE) begin
               next_tx_data = utc_pkg::ACK_BYTE;
               next_tx_valid = 1'b1;
               next_state = utc_pkg::T_ACK;
            end
         end
         utc_pkg::T_ACK: begin
            if (tx_ready_in) begin
               next_tx_valid = 1'b0;
               next_state = utc_pkg::T_WAIT_CMD;
            end
         end
         utc_pkg::T_WAIT_CMD: begin
            // only the command due next in the write-then-read order starts
            if (rx_valid_in && decoded[1] && decoded[0] == expect_read) begin
               next_start = 1'b1;
               next_dir = decoded[0] ? utc_pkg::UTC_DIR_READ :
                                       utc_pkg::UTC_DIR_WRITE;
               next_state = utc_pkg::T_RUN;
            end
         end
         utc_pkg::T_RUN: begin
            if (mst_done) begin
               next_byte_idx = 4'h0;
               next_tx_data = cnt_byte(count_mem[0], 1'b0);
               next_tx_valid = 1'b1;
               next_state = utc_pkg::T_SEND;
            end
         end
         default: begin
            if (tx_ready_in) begin
               if (byte_idx == utc_pkg::LAST_CBYTE) begin
                  next_tx_valid = 1'b0;
                  next_expect_read = !expect_read;
                  next_state = utc_pkg::T_WAIT_HS;
               end else begin
                  next_byte_idx = byte_idx + 4'h1;
                  next_tx_data = cnt_byte(count_mem[next_byte_idx[3:1]],
                                          next_byte_idx[0]);
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state <= utc_pkg::T_WAIT_HS;
         dir <= utc_pkg::UTC_DIR_WRITE;
         expect_read <= 1'b0;
         tx_valid <= 1'b0;
         tx_data <= utc_pkg::BYTE_RST;
         start <= 1'b0;
         byte_idx <= 4'h0;
      end else begin
         state <= next_state;
         dir <= next_dir;
         expect_read <= next_expect_read;
         tx_valid <= next_tx_valid;
         tx_data <= next_tx_data;
         start <= next_start;
         byte_idx <= next_byte_idx;
      end
   end

   logic busy;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         busy <= 1'b0;
      end else begin
         busy <= (next_state == utc_pkg::T_RUN);
      end
   end

   assign tx_valid_out = tx_valid;
   assign tx_data_out  = tx_data;
   assign busy_out     = busy;

   utc_axi_master u_master (
      .clk_in         (clk_in),
      .rst_b_in       (rst_b_in),
      .start_in       (start),
      .dir_in         (dir),
      .done_out       (mst_done),
      .cnt_valid_out  (cnt_valid),
      .cnt_out        (cnt),
      .ram_addr_out   (ram_addr_out),
      .ram_rd_data_in (ram_rd_data_in),
      .ram_we_out     (ram_we_out),
      .ram_wdata_out  (ram_wdata_out),
      .awaddr_out     (awaddr_out),
      .awlen_out      (awlen_out),
      .awvalid_out    (awvalid_out),
      .awready_in     (awready_in),
      .wdata_out      (wdata_out),
      .wlast_out      (wlast_out),
      .wvalid_out     (wvalid_out),
      .wready_in      (wready_in),
      .bvalid_in      (bvalid_in),
      .bready_out     (bready_out),
      .araddr_out     (araddr_out),
      .arvalid_out    (arvalid_out),
      .arready_in     (arready_in),
      .rdata_in       (rdata_in),
      .rvalid_in      (rvalid_in),
      .rready_out     (rready_out)
   );

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);

   sequence s_hs;
      state == utc_pkg::T_WAIT_HS && rx_valid_in &&
      rx_data_in == utc_pkg::HS_BYTE;
   endsequence
   sequence s_cmd(logic [7:0] b, logic rd);
      state == utc_pkg::T_WAIT_CMD && rx_valid_in && rx_data_in == b &&
      expect_read == rd;
   endsequence
   sequence s_pulse;
      start ##1 !start;
   endsequence

   AST_QUIET_BEFORE_HS: assert property (
      state == utc_pkg::T_WAIT_HS && !(rx_valid_in &&
      rx_data_in == utc_pkg::HS_BYTE) |=>
      state == utc_pkg::T_WAIT_HS && !tx_valid && !start)
      else $error("activity before handshake");
   AST_ACK_ON_HS: assert property (
      s_hs |=> tx_valid && tx_data == utc_pkg::ACK_BYTE &&
      state == utc_pkg::T_ACK)
      else $error("no acknowledge after handshake");
   AST_WRITE_START: assert property (
      s_cmd(utc_pkg::CMD_WR_BYTE, 1'b0) |=>
      dir == utc_pkg::UTC_DIR_WRITE ##0 s_pulse)
      else $error("write command did not start write");
   AST_READ_START: assert property (
      s_cmd(utc_pkg::CMD_RD_BYTE, 1'b1) |=>
      dir == utc_pkg::UTC_DIR_READ ##0 s_pulse)
      else $error("read command did not start read");
   AST_READ_AFTER_WRITE: assert property (
      s_cmd(utc_pkg::CMD_WR_BYTE, 1'b1) |=> !start)
      else $error("second write accepted before read");
   AST_COUNTS_SENT: assert property (
      state == utc_pkg::T_RUN && mst_done |=>
      tx_valid && tx_data == $past(count_mem[0][7:0]) &&
      state == utc_pkg::T_SEND)
      else $error("counts not sent after sequence");
endmodule : utc_top

// ===== utc_host_model.sv
// host side model: sends uart bytes, takes tx bytes with stalls
`timescale 1ns/1ps
module utc_host_model (
   input  wire logic       clk_in,
   input  wire logic       send_in,
   input  wire logic [7:0] byte_in,
   output logic            rx_valid_out,
   output logic [7:0]      rx_data_out,
   output logic            tx_ready_out
);
   initial {rx_valid_out, rx_data_out, tx_ready_out} = 10'h000;
   always @(posedge clk_in) begin
      rx_valid_out <= send_in;
      // idle line alternates the inverse of the last byte with the byte itself
      rx_data_out  <= send_in ? byte_in : ~rx_data_out;
      tx_ready_out <= 1'(($urandom % 3) != 0);
   end
endmodule : utc_host_model

// ===== tb_top.sv
// self-checking bench of the throughput test control
`timescale 1ns/1ps
module tb_top;
   logic        clk_in = 1'h0, rst_b_in = 1'h0, send = 1'h0, vd = 1'h0;
   logic        rx_valid_in, tx_ready_in, tx_valid_out, busy_out;
   logic [7:0]  rx_data_in, tx_data_out, ram_addr_out, sb = 8'h00;
   logic [63:0] ram_rd_data_in = 64'h0, rdata_in = 64'h0;
   logic [63:0] ram_wdata_out, wdata_out;
   logic        ram_we_out, awvalid_out, wlast_out, wvalid_out;
   logic        bready_out, arvalid_out, rready_out;
   logic        awready_in = 1'h0, wready_in = 1'h0, bvalid_in = 1'h0;
   logic        arready_in = 1'h0, rvalid_in = 1'h0;
   logic [31:0] awaddr_out, araddr_out;
   logic [3:0]  awlen_out;
   logic [15:0] cw = 16'h0000;
   logic [8:0]  txq[$];
   logic [71:0] rq[$];
   int          mq[$];
   int n_fail = 0, num_checks = 0, aw_n = 0, ar_n = 0, w_n = 0, b_n = 0;
   int r_n = 0, rw_n = 0, rl = 0, cyc = 0, st = 0, nc = 0, d, i;

   always #10 clk_in = ~clk_in;
   utc_top dut (.*);
   utc_host_model host (.clk_in(clk_in), .send_in(send), .byte_in(sb),
      .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in),
      .tx_ready_out(tx_ready_in));

   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : conclude

   task automatic put(input logic [7:0] b);
      @(posedge clk_in);
      send <= 1'h1;
      sb <= b;
      @(posedge clk_in);
      send <= 1'h0;
      repeat (4) @(posedge clk_in);
   endtask : put

   // bounded wait until all expected tx bytes came and no run is active
   task automatic settle();
      for (int k = 0; k < 60000 && (txq.size() != 0 || busy_out); k++)
         @(posedge clk_in);
      repeat (4) @(posedge clk_in);
   endtask : settle

   // axi slave and fabric ram with random stalls
   always @(posedge clk_in) begin
      ram_rd_data_in <= {8{ram_addr_out}};
      awready_in <= 1'($urandom % 2);
      wready_in <= 1'($urandom % 2);
      arready_in <= 1'($urandom % 2);
      bvalid_in <= bready_out && !bvalid_in && 1'($urandom % 2);
      if (arvalid_out && arready_in) rl += 16;
      if (rvalid_in && rready_out) rl--;
      if (!(rvalid_in && !rready_out)) begin
         rvalid_in <= rl != 0 && 1'($urandom % 2);
         rdata_in <= {$urandom, $urandom};
      end
   end

   always @(posedge clk_in) if (rst_b_in) begin
      cyc++;
      if ((awvalid_out || arvalid_out) && !vd && (aw_n + ar_n) % 16 == 0)
         st = cyc;
      vd = awvalid_out || arvalid_out;
      if (awvalid_out && awready_in) begin
         chk(awaddr_out, 72'(aw_n * 128));
         chk(awlen_out, 72'hF);
         aw_n++;
      end
      if (wvalid_out && wready_in) begin
         chk(wdata_out, {8{w_n[7:0]}});
         chk(wlast_out, 72'(w_n % 16 == 15));
         w_n++;
      end
      if (bvalid_in && bready_out && b_n++ % 16 == 15) mq.push_back(cyc - st);
      if (arvalid_out && arready_in) begin
         chk(araddr_out, 72'(ar_n * 128));
         ar_n++;
      end
      if (rvalid_in && rready_out) begin
         rq.push_back({r_n[7:0], rdata_in});
         if (r_n++ % 256 == 255) mq.push_back(cyc - st);
      end
      if (ram_we_out) begin
         chk({ram_addr_out, ram_wdata_out}, rq.pop_front());
         rw_n++;
      end
      if (tx_valid_out && tx_ready_in) begin
         if (txq.size() == 0) chk(72'h1, 72'h0);
         else if (!txq[0][8]) chk(tx_data_out, txq.pop_front());
         else begin
            void'(txq.pop_front());
            cw = {tx_data_out, cw[15:8]};
            if (nc++ % 2 == 1) begin
               // count start edge may sit a few cycles off the valid rise
               d = int'(cw) - mq.pop_front();
               chk(d >= -4 && d <= 4, 72'h1);
            end
         end
      end
   end

   initial begin
      repeat (40000) @(posedge clk_in);
      n_fail++;
      conclude();
   end

   initial begin
      void'($urandom(32'h5385));
      repeat (12) @(posedge clk_in);
      rst_b_in <= 1'h1;
      @(posedge clk_in);
      chk({tx_valid_out, busy_out, awlen_out}, 72'hF);
      put(8'h25);
      put(8'h62);
      chk({tx_valid_out, busy_out}, 72'h0);
      $display("test stray bytes done");
      txq.push_back(9'h061);
      put(8'h63);
      settle();
      put(8'h26);
      chk(busy_out, 72'h0);
      for (i = 0; i < 16; i++) txq.push_back(9'h100);
      put(8'h25);
      chk(busy_out, 72'h1);
      put(8'h63);
      settle();
      chk({aw_n, w_n}, {32'd128, 32'd2048});
      $display("test write done");
      txq.push_back(9'h061);
      put(8'h63);
      settle();
      put(8'h25);
      chk(busy_out, 72'h0);
      for (i = 0; i < 16; i++) txq.push_back(9'h100);
      put(8'h26);
      chk(busy_out, 72'h1);
      settle();
      chk({ar_n, rw_n}, {32'd128, 32'd2048});
      $display("test read done");
      conclude();
   end
endmodule : tb_top
